/* File: verilog/eqwp_device.sv */
// Memory end of the link: program cycle busy, polling answers and quadrant write protection.
`timescale 1ns/1ps
// Notes on behaviour
// - Stop after ninth clock starts cycle; memory and protection inputs ignored.
// - No address acknowledge while programming; afterwards again.
// - Master polls with Start and address until acknowledged.
// - Sensor commands still answered during program cycle.
// - Cycle runs from Stop to first acknowledged Start.
// - Four independent quadrant protection flags.
// - Identifier codes map to fixed quadrants.
// - Set command 0110MMM0 protects one quadrant.
// - Master holds high voltage during set sequence.
// - Protection persists until clear command or reset.
// - Clear is 66h, two dummy bytes, Stop, voltage held.
// - Clear dummy bytes may get either answer.
// - Clear unprotects all four quadrants together.
// - Query 0110MMM1 needs no high voltage.
// - Query unprotected: acknowledge control, refuse the rest.
// - Query protected: refuse all three bytes.
// - Write to protected quadrant refuses data, no cycle.
// - Half select clears at reset and software reset.
module eqwp_device
#(
   parameter int unsigned PROGRAM_CYCLES = eqwp_pkg::PROGRAM_CYCLE_CYCLES,
   parameter logic [2:0]  ADDR_STRAP     = 3'h0
)
(
   input  wire logic   clk,
   input  wire logic   arst_n,
   eqwp_if.device      link,
   output logic        busy,
   output logic [3:0]  quadrantWriteLock,
   output logic        halfSelect,
   output logic        programStart
);
   import eqwp_pkg::*;

   logic [1:0]   sclSync;
   logic [1:0]   sdaSync;
   logic [1:0]   hvSync;
   logic         sclPrev;
   logic         sdaPrev;
   logic         sclRise;
   logic         sclFall;
   logic         startCond;
   logic         stopCond;
   logic         active;
   logic [3:0]   bitCnt;
   logic         ackPhase;
   logic [1:0]   byteIdx;
   logic [7:0]   shiftReg;
   logic         ackMoment;
   logic         endMoment;
   eqwp_cmd_type cmd;
   eqwp_cmd_type next_cmd;
   logic         next_ack;
   logic [2:0]   quad;
   logic [1:0]   quadSel;
   logic         addrHi;
   logic         armed;
   logic         progGo;

   // Pins come from the master's domain, so each passes two flops before use.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sclSync <= 2'h3;
         sdaSync <= 2'h3;
         hvSync  <= 2'h0;
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end
      else
      begin
         sclSync <= {sclSync[0], link.scl};
         sdaSync <= {sdaSync[0], link.sda};
         hvSync  <= {hvSync[0], link.addrPinLowBitHv};
         sclPrev <= sclSync[1];
         sdaPrev <= sdaSync[1];
      end
   end

   // Edge and bus condition detection on the synchronised lines.
   assign sclRise   = sclSync[1] & ~sclPrev;
   assign sclFall   = ~sclSync[1] & sclPrev;
   assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
   assign stopCond  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];
   assign ackMoment = active & sclFall & (bitCnt == BITS_PER_BYTE) & ~ackPhase;
   assign endMoment = active & sclFall & ackPhase;
   assign quad      = quadrantOf(shiftReg[3:1]);

   // Bit and byte framing; the ninth clock is the acknowledge slot.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         active   <= 1'b0;
         bitCnt   <= 4'h0;
         ackPhase <= 1'b0;
         byteIdx  <= 2'h0;
         shiftReg <= 8'h00;
      end
      else if (startCond)
      begin
         active   <= 1'b1;
         bitCnt   <= 4'h0;
         ackPhase <= 1'b0;
         byteIdx  <= 2'h0;
      end
      else if (stopCond)
      begin
         active <= 1'b0;
      end
      else if (active && sclRise && bitCnt != BITS_PER_BYTE)
      begin
         shiftReg <= {shiftReg[6:0], sdaSync[1]};
         bitCnt   <= bitCnt + 4'h1;
      end
      else if (ackMoment)
      begin
         ackPhase <= 1'b1;
      end
      else if (endMoment)
      begin
         ackPhase <= 1'b0;
         bitCnt   <= 4'h0;
         if (byteIdx != 2'h3)
            byteIdx <= byteIdx + 2'h1;
      end
   end

   // Answer decision for the byte just received; a refused control byte
   // leaves the device deaf until the next Start.
   always_comb
   begin
      next_cmd = cmd;
      next_ack = 1'b0;
      if (byteIdx == 2'h0)
      begin
         next_cmd = CMD_NONE;
         case (shiftReg[7:4])
            TYPE_MEM:
               if (shiftReg[3:1] == ADDR_STRAP && !busy)
                  next_cmd = shiftReg[BIT_RW] ? CMD_READ : CMD_MEM_WR;
            TYPE_TS:
               if (shiftReg[3:1] == ADDR_STRAP)
                  next_cmd = shiftReg[BIT_RW] ? CMD_READ : CMD_TS_WR;
            TYPE_PROT:
               if (!busy)
               begin
                  if (quad[2] && shiftReg[BIT_RW])
                     next_cmd = quadrantWriteLock[quad[1:0]] ? CMD_NONE : CMD_QUERY;
                  else if (quad[2])
                     next_cmd = (hvSync[1] && !quadrantWriteLock[quad[1:0]]) ? CMD_SET : CMD_NONE;
                  else if (!shiftReg[BIT_RW])
                  begin
                     case (shiftReg[3:1])
                        QID_CLEAR:   next_cmd = hvSync[1] ? CMD_CLEAR : CMD_NONE;
                        QID_HALF0:   next_cmd = CMD_HALF0;
                        QID_HALF1:   next_cmd = CMD_HALF1;
                        QID_SWRESET: next_cmd = CMD_SWRESET;
                        default:     next_cmd = CMD_NONE;
                     endcase
                  end
                  else if (shiftReg[3:2] == QID_HALF0[2:1] && !halfSelect)
                     next_cmd = CMD_HALFQ;
               end
            default:
               next_cmd = CMD_NONE;
         endcase
         next_ack = (next_cmd != CMD_NONE);
      end
      else
      begin
         case (cmd)
            CMD_MEM_WR:
               next_ack = (byteIdx == 2'h1) || !quadrantWriteLock[{halfSelect, addrHi}];
            CMD_SET:     next_ack = 1'b1;
            CMD_CLEAR:   next_ack = 1'b1;
            CMD_TS_WR:   next_ack = 1'b1;
            default:     next_ack = 1'b0;
         endcase
      end
   end

   // Command capture at each acknowledge slot.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd     <= CMD_NONE;
         quadSel <= 2'h0;
         addrHi  <= 1'b0;
      end
      else if (startCond)
      begin
         cmd <= CMD_NONE;
      end
      else if (ackMoment)
      begin
         cmd <= next_cmd;
         if (byteIdx == 2'h0)
            quadSel <= quad[1:0];
         if (byteIdx == 2'h1)
            addrHi <= shiftReg[BIT_ADDR_HI];
      end
   end

   // Data line drive: pulled low only through the acknowledge slot.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         link.devSdaOe  <= 1'b0;
         link.devSdaOut <= 1'b0;
      end
      else if (startCond || stopCond || endMoment)
         link.devSdaOe <= 1'b0;
      else if (ackMoment)
         link.devSdaOe <= next_ack;
   end

   // Armed only between an accepted data byte's acknowledge and the next data bit,
   // so a Stop anywhere else triggers nothing.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         armed <= 1'b0;
      else if (startCond || stopCond)
         armed <= 1'b0;
      else if (ackMoment)
         armed <= next_ack && byteIdx[1];
      else if (active && sclFall && !ackPhase)
         armed <= 1'b0;
   end

   assign progGo = stopCond & active & armed &
                   ((cmd == CMD_MEM_WR) | (cmd == CMD_SET) | (cmd == CMD_CLEAR));

   // Protection flags survive everything except a completed clear or a reset.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         quadrantWriteLock <= LOCK_RESET;
      else if (progGo && cmd == CMD_SET)
         quadrantWriteLock[quadSel] <= 1'b1;
      else if (progGo && cmd == CMD_CLEAR)
         quadrantWriteLock <= LOCK_RESET;
   end

   // Half select acts as soon as its control byte is accepted.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         halfSelect <= HALF_RESET;
      else if (ackMoment && (next_cmd == CMD_HALF0 || next_cmd == CMD_SWRESET))
         halfSelect <= HALF_RESET;
      else if (ackMoment && next_cmd == CMD_HALF1)
         halfSelect <= 1'b1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         programStart <= 1'b0;
      else
         programStart <= progGo;
   end

   // Program cycle timer; its busy flag gates memory and protection commands, not sensor ones.
   eqwp_busy_timer #(
      .CYCLES (PROGRAM_CYCLES)
   ) u_timer (
      .clk    (clk),
      .arst_n (arst_n),
      .start  (progGo),
      .busy   (busy)
   );
endmodule : eqwp_device

/* File: verilog/eqwp_pkg.sv */
// Shared constants, command codes and decode helpers for the quadrant protect link.
package eqwp_pkg;
   // Control byte type nibbles.
   localparam logic [3:0] TYPE_MEM  = 4'ha;
   localparam logic [3:0] TYPE_PROT = 4'h6;
   localparam logic [3:0] TYPE_TS   = 4'h3;
   // Identifier field values (control byte bits 3..1).
   localparam logic [2:0] QID_Q0      = 3'h1;
   localparam logic [2:0] QID_Q1      = 3'h4;
   localparam logic [2:0] QID_Q2      = 3'h5;
   localparam logic [2:0] QID_Q3      = 3'h0;
   localparam logic [2:0] QID_CLEAR   = 3'h3;
   localparam logic [2:0] QID_SWRESET = 3'h2;
   localparam logic [2:0] QID_HALF0   = 3'h6;
   localparam logic [2:0] QID_HALF1   = 3'h7;
   // Bit positions inside a byte.
   localparam int BIT_RW      = 0;
   localparam int BIT_ADDR_HI = 7;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // Timing: program cycle length and link quarter period of the host.
   localparam int CLK_MHZ                = 200;
   localparam int PROGRAM_CYCLE_TIME_US  = 1000;
   localparam int PROGRAM_CYCLE_CYCLES   = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
   localparam int HOST_QUARTER_CYCLES    = 30;
   // Reset values.
   localparam logic [3:0] LOCK_RESET = 4'h0;
   localparam logic       HALF_RESET = 1'b0;

   typedef enum {CMD_NONE, CMD_MEM_WR, CMD_READ, CMD_TS_WR, CMD_SET, CMD_CLEAR,
                 CMD_QUERY, CMD_HALF0, CMD_HALF1, CMD_SWRESET, CMD_HALFQ} eqwp_cmd_type;

   // Maps an identifier field to {valid, quadrant index}.
   function automatic logic [2:0] quadrantOf(input logic [2:0] qid);
      case (qid)
         QID_Q0:  quadrantOf = 3'h4;
         QID_Q1:  quadrantOf = 3'h5;
         QID_Q2:  quadrantOf = 3'h6;
         QID_Q3:  quadrantOf = 3'h7;
         default: quadrantOf = 3'h0;
      endcase
   endfunction : quadrantOf
endpackage : eqwp_pkg

/* File: verilog/eqwp_if.sv */
// Two-wire link between the master end and the memory end, with wired-AND resolution.
`timescale 1ns/1ps
interface eqwp_if;
   logic scl;
   logic sda;
   logic hostSclOut;
   logic hostSclOe;
   logic hostSdaOut;
   logic hostSdaOe;
   logic devSdaOut;
   logic devSdaOe;
   logic addrPinLowBitHv;

   // Open-drain lines: any enabled low driver pulls the wire low, otherwise the pull-up wins.
   assign scl = ~(hostSclOe & ~hostSclOut);
   assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

   modport host (input scl, input sda, output hostSclOut, output hostSclOe,
                 output hostSdaOut, output hostSdaOe, output addrPinLowBitHv);
   modport device (input scl, input sda, input addrPinLowBitHv,
                   output devSdaOut, output devSdaOe);
endinterface : eqwp_if

/* File: verilog/eqwp_busy_timer.sv */
// Self-timed program cycle counter that holds busy for a fixed number of clocks.
`timescale 1ns/1ps
module eqwp_busy_timer
#(
   parameter int unsigned CYCLES = 1000
)
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic start,
   output logic      busy
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] count;

   // A start while already busy is ignored; the device never issues one.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count <= '0;
         busy  <= 1'b0;
      end
      else if (start && !busy)
      begin
         count <= CW'(CYCLES - 1);
         busy  <= 1'b1;
      end
      else if (busy)
      begin
         count <= count - 1'b1;
         busy  <= (count != '0);
      end
   end
endmodule : eqwp_busy_timer

/* File: verilog/eqwp_host.sv */
// Master end of the link: issues one to three byte sequences with optional polling and high voltage.
`timescale 1ns/1ps
module eqwp_host
#(
   parameter int unsigned QUARTER_DIV = eqwp_pkg::HOST_QUARTER_CYCLES
)
(
   input  wire logic  clk,
   input  wire logic  arst_n,
   eqwp_if.host       link,
   input  wire logic  reqValid,
   output logic       reqReady,
   input  wire logic [7:0] reqCtrl,
   input  wire logic [7:0] reqAddr,
   input  wire logic [7:0] reqData,
   input  wire logic [1:0] reqBytes,
   input  wire logic  reqHv,
   input  wire logic  reqPoll,
   output logic       doneValid,
   output logic [2:0] doneAcks
);
   import eqwp_pkg::*;

   typedef enum {H_IDLE, H_START, H_BIT, H_STOP} eqwp_hstate_type;
   localparam int DW = $clog2(QUARTER_DIV + 1);

   eqwp_hstate_type state;
   logic [1:0]      sdaSync;
   logic [DW-1:0]   divCnt;
   logic            tick;
   logic [1:0]      phase;
   logic [3:0]      bitCnt;
   logic [1:0]      byteIdx;
   logic [7:0]      shiftReg;
   logic [7:0]      addrHold;
   logic [7:0]      dataHold;
   logic [7:0]      ctrlHold;
   logic [1:0]      lastIdx;
   logic            readDir;
   logic            poll;

   // Data line readback comes through two flops.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         sdaSync <= 2'h3;
      else
         sdaSync <= {sdaSync[0], link.sda};
   end

   // Quarter-bit enable; the host makes the link clock itself from this divider.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         divCnt <= '0;
         tick   <= 1'b0;
      end
      else
      begin
         tick   <= (state != H_IDLE) && (divCnt == DW'(QUARTER_DIV - 1));
         divCnt <= (state == H_IDLE || divCnt == DW'(QUARTER_DIV - 1)) ? '0 : divCnt + 1'b1;
      end
   end

   // Sequencer: Start, bytes with an acknowledge slot each, Stop right after the last slot.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state    <= H_IDLE;
         reqReady <= 1'b1;
         doneValid <= 1'b0;
         doneAcks <= 3'h0;
         phase    <= 2'h0;
         bitCnt   <= 4'h0;
         byteIdx  <= 2'h0;
         shiftReg <= 8'h00;
         addrHold <= 8'h00;
         dataHold <= 8'h00;
         ctrlHold <= 8'h00;
         lastIdx  <= 2'h0;
         readDir  <= 1'b0;
         poll     <= 1'b0;
         link.hostSclOe   <= 1'b0;
         link.hostSdaOe   <= 1'b0;
         link.hostSclOut  <= 1'b0;
         link.hostSdaOut  <= 1'b0;
         link.addrPinLowBitHv <= 1'b0;
      end
      else
      begin
         doneValid <= 1'b0;
         case (state)
            H_IDLE:
               if (reqValid && reqReady)
               begin
                  reqReady <= 1'b0;
                  shiftReg <= reqCtrl;
                  addrHold <= reqAddr;
                  dataHold <= reqData;
                  ctrlHold <= reqCtrl; // Kept whole, as the shifter is empty after eight bits.
                  lastIdx  <= (reqBytes == 2'h0) ? 2'h0 : reqBytes - 2'h1;
                  readDir  <= reqCtrl[BIT_RW];
                  poll     <= reqPoll;
                  doneAcks <= 3'h0;
                  phase    <= 2'h0;
                  link.addrPinLowBitHv <= reqHv;
                  state    <= H_START;
               end
            H_START:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: link.hostSdaOe <= 1'b0;
                     2'h1: link.hostSclOe <= 1'b0;
                     2'h2: link.hostSdaOe <= 1'b1;
                     default:
                     begin
                        link.hostSclOe <= 1'b1;
                        bitCnt  <= 4'h0;
                        byteIdx <= 2'h0;
                        state   <= H_BIT;
                     end
                  endcase
               end
            H_BIT:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: link.hostSdaOe <= (bitCnt != BITS_PER_BYTE) &&
                                             (byteIdx == 2'h0 || !readDir) && !shiftReg[7];
                     2'h1: link.hostSclOe <= 1'b0;
                     2'h2: if (bitCnt == BITS_PER_BYTE) doneAcks[byteIdx] <= !sdaSync[1];
                     default:
                     begin
                        link.hostSclOe <= 1'b1;
                        if (bitCnt != BITS_PER_BYTE)
                        begin
                           shiftReg <= {shiftReg[6:0], 1'b0};
                           bitCnt   <= bitCnt + 4'h1;
                        end
                        else if (poll && byteIdx == 2'h0 && !doneAcks[0])
                        begin
                           shiftReg <= ctrlHold;
                           state    <= H_START;
                        end
                        else if (byteIdx == lastIdx)
                           state <= H_STOP;
                        else
                        begin
                           bitCnt   <= 4'h0;
                           byteIdx  <= byteIdx + 2'h1;
                           shiftReg <= (byteIdx == 2'h0) ? addrHold : dataHold;
                        end
                     end
                  endcase
               end
            H_STOP:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0: link.hostSdaOe <= 1'b1;
                     2'h1: link.hostSclOe <= 1'b0;
                     2'h2: link.hostSdaOe <= 1'b0;
                     default:
                     begin
                        link.addrPinLowBitHv <= 1'b0;
                        reqReady  <= 1'b1;
                        doneValid <= 1'b1;
                        state     <= H_IDLE;
                     end
                  endcase
               end
            default:
               state <= H_IDLE;
         endcase
      end
   end
endmodule : eqwp_host

/* File: verification/eqwp_link_monitor.sv */
// Concurrent checks on the shared link and the memory end's status outputs.
`timescale 1ns/1ps
module eqwp_link_monitor
#(
   parameter int unsigned PROGRAM_CYCLES = 1000
)
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       devSdaOe,
   input  wire logic       addrPinLowBitHv,
   input  wire logic       busy,
   input  wire logic       programStart,
   input  wire logic [3:0] quadrantWriteLock
);
   logic [31:0] busyRun;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Length of the running busy spell; a counter avoids a huge repetition.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         busyRun <= 32'h0;
      else if (busy)
         busyRun <= busyRun + 32'h1;
      else
         busyRun <= 32'h0;
   end

   // The high voltage may only move while the bus is idle.
   hv_idle_a: assert property ($changed(addrPinLowBitHv) |-> scl && sda)
      else $error("high voltage moved during a frame");
   dev_edge_a: assert property ($changed(devSdaOe) |-> !scl)
      else $error("memory end moved sda while scl high");
   ack_hold_a: assert property (devSdaOe && scl |=> devSdaOe || !scl)
      else $error("acknowledge dropped during scl high");
   busy_start_a: assert property (programStart |-> ##[1:8] busy)
      else $error("program start without busy");
   busy_len_a: assert property ($fell(busy) |-> busyRun >= PROGRAM_CYCLES - 2 && busyRun <= PROGRAM_CYCLES + 2)
      else $error("program cycle length wrong");
   lock_step_a: assert property ($changed(quadrantWriteLock) |-> quadrantWriteLock == 4'h0
      || ($countones(quadrantWriteLock ^ $past(quadrantWriteLock)) == 1
      && (quadrantWriteLock & $past(quadrantWriteLock)) == $past(quadrantWriteLock)))
      else $error("lock changed other than one set or clear all");
   lock_idle_a: assert property ($changed(quadrantWriteLock) |-> scl && sda)
      else $error("lock changed inside a frame");
   start_idle_a: assert property (programStart |-> scl && sda)
      else $error("program start inside a frame");
   cycle_ignore_a: assert property ($past(busy) |-> !programStart)
      else $error("program start while busy");

   cover property (programStart);
   cover property (busy && devSdaOe);
   cover property (quadrantWriteLock == 4'hf);
   cover property ($fell(|quadrantWriteLock));
endmodule : eqwp_link_monitor

/* File: verification/eeprom_quadrant_write_protect_bench.sv */
// Self-checking bench joining the master and memory ends over one link.
`timescale 1ns/1ps
module eeprom_quadrant_write_protect_bench;
   import eqwp_pkg::*;
   localparam int unsigned CYC = 1000;
   logic       clk;
   logic       arst_n;
   logic       reqValid;
   logic       reqReady;
   logic [7:0] reqCtrl;
   logic [7:0] reqAddr;
   logic [7:0] reqData;
   logic [1:0] reqBytes;
   logic       reqHv;
   logic       reqPoll;
   logic       doneValid;
   logic [2:0] doneAcks;
   logic       busy;
   logic [3:0] quadrantWriteLock;
   logic       halfSelect;
   logic       programStart;
   logic [3:0] lockSeen;
   logic [2:0] qidTable [4];
   int         badCount;
   int         checkCount;

   eqwp_if eqwp_if_inst ();
   eqwp_host #(.QUARTER_DIV(6)) eqwp_host_inst (.clk(clk), .arst_n(arst_n), .link(eqwp_if_inst.host),
      .reqValid(reqValid), .reqReady(reqReady), .reqCtrl(reqCtrl), .reqAddr(reqAddr), .reqData(reqData),
      .reqBytes(reqBytes), .reqHv(reqHv), .reqPoll(reqPoll), .doneValid(doneValid), .doneAcks(doneAcks));
   eqwp_device #(.PROGRAM_CYCLES(CYC)) eqwp_device_inst (.clk(clk), .arst_n(arst_n),
      .link(eqwp_if_inst.device), .busy(busy), .quadrantWriteLock(quadrantWriteLock),
      .halfSelect(halfSelect), .programStart(programStart));
   eqwp_link_monitor #(.PROGRAM_CYCLES(CYC)) eqwp_link_monitor_inst (.clk(clk), .arst_n(arst_n),
      .scl(eqwp_if_inst.scl), .sda(eqwp_if_inst.sda), .devSdaOe(eqwp_if_inst.devSdaOe),
      .addrPinLowBitHv(eqwp_if_inst.addrPinLowBitHv), .busy(busy), .programStart(programStart),
      .quadrantWriteLock(quadrantWriteLock));

   // Prints the counts and the verdict, then stops.
   task automatic endSim();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : endSim

   // Compares a set of acknowledge bits.
   task automatic cmpAcks(input string what, input logic [2:0] expv, input logic [2:0] got);
      checkCount++;
      if (got !== expv)
      begin
         badCount++;
         $display("unexpected %s expected %b seen %b", what, expv, got);
      end
   endtask : cmpAcks

   // Compares a status output of the memory end.
   task automatic cmpState(input string what, input logic [3:0] expv, input logic [3:0] got);
      checkCount++;
      if (got !== expv)
      begin
         badCount++;
         $display("unexpected %s expected %h seen %h", what, expv, got);
      end
   endtask : cmpState

   // One master sequence; status is read a few clocks later because the memory end synchronises.
   task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic [1:0] n,
                       input logic hv, input logic poll);
      int k;
      reqCtrl = c;
      reqAddr = a;
      reqData = ~a;
      reqBytes = n;
      reqHv = hv;
      reqPoll = poll;
      reqValid = 1'b1;
      while (reqReady !== 1'b1)
         @(posedge clk) #1;
      @(posedge clk) #1;
      reqValid = 1'b0;
      k = 0;
      while (doneValid !== 1'b1 && k < 6000)
      begin
         @(posedge clk) #1;
         k++;
      end
      cmpState("done", 4'h1, {3'h0, doneValid});
      repeat (8) @(posedge clk);
      #1;
   endtask : xfer

   // Polls until the program cycle has ended.
   task automatic pollFree();
      xfer(8'ha0, 8'h00, 2'h1, 1'b0, 1'b1);
      cmpAcks("poll ack", 3'h1, doneAcks);
      cmpState("busy after poll", 4'h0, {3'h0, busy});
   endtask : pollFree

   // Free-running core clock.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cuts a hang short well past the expected run time.
   initial
   begin
      #500000;
      badCount++;
      endSim();
   end

   // Main sequence of master transfers.
   initial
   begin
      badCount = 0;
      checkCount = 0;
      arst_n = 1'b0;
      reqValid = 1'b0;
      reqCtrl = 8'h00;
      reqAddr = 8'h00;
      reqData = 8'h00;
      reqBytes = 2'h1;
      reqHv = 1'b0;
      reqPoll = 1'b0;
      lockSeen = 4'h0;
      qidTable = '{QID_Q0, QID_Q1, QID_Q2, QID_Q3};
      repeat (6) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      cmpState("reset lock", 4'h0, quadrantWriteLock);
      cmpState("reset half", 4'h0, {3'h0, halfSelect});
      xfer(8'h63, 8'h00, 2'h3, 1'b0, 1'b0);
      cmpAcks("query free", 3'h1, doneAcks);
      xfer(8'h62, 8'h00, 2'h3, 1'b0, 1'b0);
      cmpAcks("set no hv", 3'h0, doneAcks);
      for (int i = 0; i < 4; i++)
      begin
         xfer({TYPE_PROT, qidTable[i], 1'b0}, 8'h00, 2'h3, 1'b1, 1'b0);
         cmpAcks("set acks", 3'h7, doneAcks);
         cmpState("busy", 4'h1, {3'h0, busy});
         if (i == 0)
         begin
            xfer({TYPE_TS, 3'h0, 1'b0}, 8'h00, 2'h1, 1'b0, 1'b0);
            cmpAcks("sensor ack", 3'h1, doneAcks);
            xfer(8'ha0, 8'h00, 2'h1, 1'b0, 1'b0);
            cmpAcks("busy refusal", 3'h0, doneAcks);
         end
         pollFree();
         lockSeen[i] = 1'b1;
         cmpState("lock", lockSeen, quadrantWriteLock);
      end
      xfer({TYPE_PROT, QID_Q1, 1'b1}, 8'h00, 2'h3, 1'b0, 1'b0);
      cmpAcks("query locked", 3'h0, doneAcks);
      xfer({TYPE_PROT, QID_Q2, 1'b0}, 8'h00, 2'h3, 1'b1, 1'b0);
      cmpAcks("set again", 3'h0, doneAcks);
      xfer(8'ha0, 8'h10, 2'h3, 1'b0, 1'b0);
      cmpAcks("locked write", 3'h3, doneAcks);
      cmpState("locked write busy", 4'h0, {3'h0, busy});
      xfer(8'h66, 8'h00, 2'h3, 1'b0, 1'b0);
      cmpAcks("clear no hv", 3'h0, doneAcks);
      cmpState("lock kept", 4'hf, quadrantWriteLock);
      xfer(8'h66, 8'h00, 2'h3, 1'b1, 1'b0);
      cmpAcks("clear acks", 3'h7, doneAcks);
      cmpState("lock cleared", 4'h0, quadrantWriteLock);
      pollFree();
      xfer({TYPE_PROT, QID_Q3, 1'b1}, 8'h00, 2'h3, 1'b0, 1'b0);
      cmpAcks("query freed", 3'h1, doneAcks);
      xfer(8'ha0, 8'h85, 2'h3, 1'b0, 1'b0);
      cmpAcks("free write", 3'h7, doneAcks);
      cmpState("free write busy", 4'h1, {3'h0, busy});
      pollFree();
      xfer({TYPE_PROT, QID_HALF1, 1'b0}, 8'h00, 2'h1, 1'b0, 1'b0);
      cmpState("half one", 4'h1, {3'h0, halfSelect});
      xfer({TYPE_PROT, QID_SWRESET, 1'b0}, 8'h00, 2'h1, 1'b0, 1'b0);
      cmpState("soft reset half", 4'h0, {3'h0, halfSelect});
      xfer({TYPE_PROT, QID_HALF1, 1'b0}, 8'h00, 2'h1, 1'b0, 1'b0);
      xfer({TYPE_PROT, QID_HALF1, 1'b1}, 8'h00, 2'h1, 1'b0, 1'b0);
      cmpAcks("half query one", 3'h0, doneAcks);
      xfer({TYPE_PROT, QID_Q3, 1'b0}, 8'h00, 2'h3, 1'b1, 1'b0);
      cmpState("lock q3", 4'h8, quadrantWriteLock);
      // A reset in mid cycle must drop busy, locks and half select together.
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      arst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      cmpState("rerun lock", 4'h0, quadrantWriteLock);
      cmpState("rerun half", 4'h0, {3'h0, halfSelect});
      cmpState("rerun busy", 4'h0, {3'h0, busy});
      xfer({TYPE_PROT, QID_HALF1, 1'b1}, 8'h00, 2'h1, 1'b0, 1'b0);
      cmpAcks("half query zero", 3'h1, doneAcks);
      endSim();
   end
endmodule : eeprom_quadrant_write_protect_bench
